// ### logic/dco_offset_reg.v
// Downstream comparator offset register and threshold code generation.
// Assumes a same-clock register write/read port and an early-edge level.
`include "dco_regs.vh"
module dco_offset_reg (
	clk_sys,
	rst_n,
	wr_en,
	wr_data,
	rd_data,
	stop_edge_polarity,
	early_edge_seen,
	downstream_return_offset,
	downstream_initial_offset,
	threshold_code
);
	input wire clk_sys;
	input wire rst_n;
	input wire wr_en;
	input wire [15:0] wr_data;
	output reg [15:0] rd_data;
	input wire stop_edge_polarity;
	input wire early_edge_seen;
	output reg [7:0] downstream_return_offset;
	output reg [6:0] downstream_initial_offset;
	output reg signed [12:0] threshold_code;

	// Threshold source selection codes
	localparam [1:0] SRC_POS = 2'b00;
	localparam [1:0] SRC_NEG = 2'b01;
	localparam [1:0] SRC_RET = 2'b10;

	// Stored return offset and its next value
	reg [7:0] ret_reg;
	reg [7:0] ret_next;

	// Stored initial offset and its next value
	reg [6:0] init_reg;
	reg [6:0] init_next;

	// Register image as read back
	reg [15:0] rd_next;

	// Threshold source and next code
	reg [1:0] src_sel;
	reg [12:0] code_next;

	// Sign-extend the return offset to code width
	function [12:0] ret_to_code;
		input [7:0] ret;
		begin
			ret_to_code = {{5{ret[7]}}, ret};
		end
	endfunction

	// Magnitude of the initial threshold
	function [12:0] init_magnitude;
		input [6:0] init;
		begin
			init_magnitude = `DCO_MID_CODE + {6'h00, init};
		end
	endfunction

	// Two's-complement negation at code width
	function [12:0] negate_code;
		input [12:0] value;
		begin
			negate_code = (~value) + 13'h0001;
		end
	endfunction

	// Pack next-state fields; reserved bit reads zero
	function [15:0] pack_image;
		input [7:0] ret;
		input [6:0] init;
		begin
			pack_image = {ret, 1'b0, init};
		end
	endfunction

	// Return offset field update
	always @* begin
		ret_next = ret_reg;
		if (wr_en) begin
			ret_next = wr_data[`DCO_RET_MSB:`DCO_RET_LSB]; // [R01]
		end
	end

	// Initial offset field update; bit 7 of the word is dropped
	always @* begin
		init_next = init_reg;
		if (wr_en) begin
			init_next = wr_data[`DCO_INIT_MSB:`DCO_INIT_LSB]; // [R06]
		end
	end

	// Read-back image
	always @* begin
		rd_next = pack_image(ret_next, init_next); // [R06]
	end

	// Initial offset until early edge, then return offset
	always @* begin
		src_sel = SRC_POS;
		if (early_edge_seen) begin
			src_sel = SRC_RET; // [R01]
		end else if (stop_edge_polarity) begin
			src_sel = SRC_NEG; // [R04]
		end else begin
			src_sel = SRC_POS; // [R03]
		end
	end

	// Code uses stored fields, one cycle after a write
	always @* begin
		case (src_sel)
			SRC_POS: begin
				code_next = init_magnitude(init_reg); // [R03] [R05]
			end
			SRC_NEG: begin
				code_next = negate_code(init_magnitude(init_reg)); // [R04]
			end
			SRC_RET: begin
				code_next = ret_to_code(ret_reg); // [R02]
			end
			default: begin
				code_next = `DCO_CODE_RESET;
			end
		endcase
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			ret_reg <= `DCO_RET_RESET;
		end else begin
			ret_reg <= ret_next;
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			init_reg <= `DCO_INIT_RESET;
		end else begin
			init_reg <= init_next;
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			rd_data <= `DCO_RESET_VAL;
		end else begin
			rd_data <= rd_next;
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			downstream_return_offset <= `DCO_RET_RESET;
		end else begin
			downstream_return_offset <= ret_next; // [R01]
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			downstream_initial_offset <= `DCO_INIT_RESET;
		end else begin
			downstream_initial_offset <= init_next;
		end
	end

	always @(posedge clk_sys) begin
		if (!rst_n) begin
			threshold_code <= `DCO_CODE_RESET;
		end else begin
			threshold_code <= code_next;
		end
	end
endmodule // dco_offset_reg

// ### logic/dco_regs.vh
// Constants for the downstream comparator offset register.
// Assumes the serial register interface delivers write strobes and data.
// Functional notes
// R01: Bits 15:8 hold return offset; threshold switches to it after early edge.
// R02: Return offset is signed two's complement, 80h..FFh negative.
// R03: Stop polarity zero (rising edge) makes initial offset positive.
// R04: Stop polarity one (falling edge) makes initial offset negative.
// R05: Initial threshold code is 1152 plus field, full scale 3072.
// R06: Bit 7 reserved, ignored on write, reads zero; field in bits 6:0.
`ifndef DCO_REGS_VH
`define DCO_REGS_VH
`define DCO_RET_MSB 15
`define DCO_RET_LSB 8
`define DCO_INIT_MSB 6
`define DCO_INIT_LSB 0
`define DCO_RESET_VAL 16'h0000
`define DCO_RET_RESET 8'h00
`define DCO_INIT_RESET 7'h00
`define DCO_CODE_RESET 13'h0000
`define DCO_RSV_BIT 7
`define DCO_MID_CODE 13'h0480
`define DCO_FULL_SCALE 13'h0c00
`endif

// ### testbench/dco_host.sv
// Host side: one-cycle register writes
module dco_host(input wire logic clk_sys,output logic wr_en=0,
output logic [15:0] wr_data=0);
timeunit 1ns;timeprecision 1ns;
task put(input logic [15:0] d);@(posedge clk_sys);wr_en<=1;wr_data<=d;
@(posedge clk_sys);wr_en<=0;wr_data<=~d;endtask
endmodule // dco_host

// ### testbench/dco_offset_reg_assertions.sv
// Checker bound to dco_offset_reg ports
module dco_chk(input wire logic clk_sys,rst_n,wr_en,early_edge_seen,
stop_edge_polarity,input wire logic [15:0] wr_data,rd_data,
input wire logic [7:0] downstream_return_offset,
input wire logic [6:0] downstream_initial_offset,
input wire logic signed [12:0] threshold_code);
timeunit 1ns;timeprecision 1ns;
AST_WR: assert property(@(posedge clk_sys) disable iff(!rst_n)
wr_en|=>rd_data=={$past(wr_data[15:8]),1'b0,$past(wr_data[6:0])})
else $error("wr");
AST_POS: assert property(@(posedge clk_sys) disable iff(!rst_n)
$past(rst_n&&!early_edge_seen&&!stop_edge_polarity)|->
threshold_code==1152+$past(rd_data[6:0])) else $error("pos");
AST_NEG: assert property(@(posedge clk_sys) disable iff(!rst_n)
$past(rst_n&&!early_edge_seen&&stop_edge_polarity)|->
13'(threshold_code+13'd1152+13'($past(rd_data[6:0])))==13'h0000)
else $error("neg");
AST_RET: assert property(@(posedge clk_sys) disable iff(!rst_n)
$past(rst_n&&early_edge_seen)|->
threshold_code==$signed($past(rd_data[15:8]))) else $error("ret");
AST_FLD: assert property(@(posedge clk_sys) disable iff(!rst_n)
downstream_return_offset==rd_data[15:8]&&
downstream_initial_offset==rd_data[6:0]) else $error("fld");
AST_RSV: assert property(@(posedge clk_sys) disable iff(!rst_n)
rd_data[7]==1'b0) else $error("rsv");
endmodule // dco_chk
bind dco_offset_reg dco_chk dco_chk_i(.*);

// ### testbench/dco_offset_reg_test.sv
// Bench: host model writes, outputs compared
module dco_offset_reg_test;
timeunit 1ns;timeprecision 1ns;
logic clk_sys=0,rst_n=0,p=0,e=0,wr_en;logic [15:0] wr_data,rd;
logic signed [12:0] t;logic [7:0] ro;logic [6:0] io;
int miscompares=0,samples_checked=0;
initial forever #10 clk_sys=~clk_sys;
dco_host dco_host_i(.*);
dco_offset_reg dco_offset_reg_i(.clk_sys,.rst_n,.wr_en,.wr_data,.rd_data(rd),
.stop_edge_polarity(p),.early_edge_seen(e),.downstream_return_offset(ro),
.downstream_initial_offset(io),.threshold_code(t));
task cmp(input logic [15:0] g,x);samples_checked++;if(g!==x)begin
miscompares++;$display("mismatch %0t %h %h",$time,g,x);end endtask
task cmp_code(input logic signed [12:0] g,input logic [15:0] x);
samples_checked++;if(16'(g)!==x)begin miscompares++;
$display("mismatch %0t %h %h",$time,16'(g),x);end endtask
task complete_run;$display("%0d %0d",miscompares,samples_checked);
if(miscompares==0&&samples_checked>0)$display("Simulation passed");
else $display("Simulation failed");$finish;endtask
task scn_pos;@(posedge clk_sys);p<=0;e<=0;dco_host_i.put(16'h85ff);
@(posedge clk_sys);#1;
cmp(rd,16'h857f);
cmp({8'h00,ro},16'h0085);
cmp({9'h000,io},16'h007f);
cmp_code(t,16'h04ff);
endtask
task scn_neg;@(posedge clk_sys);p<=1;e<=0;dco_host_i.put(16'h0380);
@(posedge clk_sys);#1;
cmp(rd,16'h0300);
cmp_code(t,16'hfb80);
endtask
task scn_ret;@(posedge clk_sys);p<=0;e<=1;dco_host_i.put(16'h7fff);
@(posedge clk_sys);#1;
cmp(rd,16'h7f7f);
cmp_code(t,16'h007f);
@(posedge clk_sys);dco_host_i.put(16'h8500);@(posedge clk_sys);#1;
cmp_code(t,16'hff85);
endtask
task scn_reset;@(posedge clk_sys);rst_n<=0;p<=0;e<=0;
repeat(2)@(posedge clk_sys);#1;
cmp(rd,16'h0000);
cmp_code(t,16'h0000);
@(posedge clk_sys);rst_n<=1;@(posedge clk_sys);#1;
cmp_code(t,16'h0480);
endtask
initial begin repeat(3)@(posedge clk_sys);rst_n<=1;
scn_pos;
scn_neg;
scn_ret;
scn_reset;
complete_run;end
endmodule // dco_offset_reg_test
